// ==== src/ebrg_params.svh ====
// Purpose: Timing and reset constants for the external bus request/grant block
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef EBRG_PARAMS_SVH
`define EBRG_PARAMS_SVH
`define EBRG_SYNC_STAGES 2
`define EBRG_RST_GRANT 1'b0
`define EBRG_RST_STATE 2'h0
`define EBRG_RST_SEL 1'b1
`endif

// ==== src/ebrg_pkg.sv ====
// Purpose: Types for the external bus request/grant block
// Assumes: Nothing
// Notes: State encoding of the arbiter
package ebrg_pkg;
	typedef enum logic [1:0] {
		EBRG_OWN = 2'h0,
		EBRG_WAIT = 2'h1,
		EBRG_GRANT = 2'h2
	} ebrg_state_t;
endpackage

// ==== src/ebrg_sync.sv ====
// Purpose: Two-flop level synchroniser
// Assumes: Asynchronous input level
// Notes: First flop feeds only the second
`timescale 1ns/10ps
`default_nettype none
module ebrg_sync (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;

	// Next values; reset value is idle high for active-low pins
	always_comb begin
		meta_d = i_ce ? i_async : meta_q;
		sync_d = i_ce ? meta_q : sync_q;
	end

	// Registers only
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign o_sync = sync_q;
endmodule
`default_nettype wire

// ==== src/ebrg_arbiter.sv ====
// Purpose: Hands the external memory bus to an outside master and takes it back
// Assumes: Core marks access boundaries with i_acc_busy and i_acc_need
// Notes: i_rst_b is the clock-domain reset of this logic only; the chip reset pin
//        is a plain input so arbitration runs through chip reset
`timescale 1ns/10ps
`default_nettype none
`include "ebrg_params.svh"
module ebrg_arbiter
	import ebrg_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_ce,
	input wire logic i_bus_request_n,
	input wire logic i_emulator_bus_request_n,
	input wire logic i_chip_reset_n,
	input wire logic i_emulator_reset_n,
	input wire logic i_emulator_enable,
	input wire logic i_go_mode,
	input wire logic i_acc_busy,
	input wire logic i_acc_need,
	output logic o_bus_grant_n,
	output logic o_bus_grant_n_oe,
	output logic o_emulator_bus_grant_n,
	output logic o_grant_hung_n,
	output logic o_bus_drive_en,
	output logic o_core_halt,
	output logic o_core_reset_n
);
	logic br_sync;
	logic ebr_sync;
	logic rst_sync;
	logic erst_sync;
	logic ee_sync;
	logic req;
	ebrg_state_t state_q;
	ebrg_state_t state_d;
	logic hung_q;
	logic hung_d;
	logic halt_q;
	logic halt_d;
	logic csel_q;
	logic csel_d;

	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	ebrg_sync u_sync_br (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_bus_request_n), .o_sync(br_sync));
	ebrg_sync u_sync_ebr (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_emulator_bus_request_n), .o_sync(ebr_sync));
	ebrg_sync u_sync_rst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_chip_reset_n), .o_sync(rst_sync));
	ebrg_sync u_sync_erst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(i_emulator_reset_n), .o_sync(erst_sync));
	ebrg_sync u_sync_ee (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_async(~i_emulator_enable), .o_sync(ee_sync));

	// Source selection follows emulator enable; ee_sync is active low
	assign req = ee_sync ? ~br_sync : ~ebr_sync;
	assign o_core_reset_n = ee_sync ? rst_sync : erst_sync;

	// -----------------------------------------------------------------
	// Arbiter next state
	// -----------------------------------------------------------------
	// Chip reset is deliberately not a term here so grant works through it
	always_comb begin
		state_d = state_q;
		hung_d = 1'b0;
		halt_d = 1'b0;
		csel_d = ee_sync;
		case (state_q)
			EBRG_OWN: begin
				if (req && i_acc_busy) begin
					state_d = EBRG_WAIT;
				end else if (req) begin
					state_d = EBRG_GRANT;
					halt_d = !i_go_mode || i_acc_need;
					hung_d = i_go_mode && i_acc_need;
				end
			end
			EBRG_WAIT: begin
				// Access boundary reached, so grant may fall mid-instruction
				if (!req) begin
					state_d = EBRG_OWN;
				end else if (!i_acc_busy) begin
					state_d = EBRG_GRANT;
					halt_d = !i_go_mode || i_acc_need;
					hung_d = i_go_mode && i_acc_need;
				end
			end
			EBRG_GRANT: begin
				if (!req) begin
					state_d = EBRG_OWN;
				end else begin
					// Halt sticks once taken; resume only on release
					halt_d = halt_q || !i_go_mode || i_acc_need;
					hung_d = halt_q || i_acc_need;
				end
			end
			default: begin
				state_d = EBRG_OWN;
			end
		endcase
		if (!i_ce) begin
			state_d = state_q;
			hung_d = hung_q;
			halt_d = halt_q;
			csel_d = csel_q;
		end
	end

	// Registers only
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q <= ebrg_state_t'(`EBRG_RST_STATE);
			hung_q <= `EBRG_RST_GRANT;
			halt_q <= `EBRG_RST_GRANT;
			csel_q <= `EBRG_RST_SEL;
		end else begin
			state_q <= state_d;
			hung_q <= hung_d;
			halt_q <= halt_d;
			csel_q <= csel_d;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	// Bus drivers float exactly while granted; target obeys grant in emulation
	always_comb begin
		o_bus_drive_en = (state_q != EBRG_GRANT);
		o_bus_grant_n = ~((state_q == EBRG_GRANT) && csel_q);
		o_bus_grant_n_oe = csel_q;
		o_emulator_bus_grant_n = ~((state_q == EBRG_GRANT) && !csel_q);
		o_grant_hung_n = ~hung_q;
		o_core_halt = halt_q;
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	grant_floats_bus_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(state_q == EBRG_GRANT) |-> !o_bus_drive_en)
		else $error("bus driven while granted");
	busy_blocks_grant_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state_q != EBRG_GRANT && i_acc_busy) |=> (state_q != EBRG_GRANT))
		else $error("grant during access");
	idle_grant_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state_q == EBRG_OWN && req && !i_acc_busy) |=> (state_q == EBRG_GRANT))
		else $error("grant not given next cycle");
	release_resume_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state_q == EBRG_GRANT && !req) |=> (o_bus_drive_en && !o_core_halt
		&& o_grant_hung_n))
		else $error("no resume after release");
	go_mode_runs_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state_q == EBRG_OWN && req && !i_acc_busy && i_go_mode && !i_acc_need)
		|=> !o_core_halt)
		else $error("halted in continue mode");
	hung_needs_grant_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		!o_grant_hung_n |-> (state_q == EBRG_GRANT))
		else $error("hung without grant");
	emu_floats_grant_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		!csel_q |-> (!o_bus_grant_n_oe && o_bus_grant_n))
		else $error("normal grant driven in emulation");
	// Looks back only over cycles free of logic reset, which refills the flops with idle
	sync_delay_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && $past(i_ce) && $past(i_ce, 2) && $past(i_rst_b) && $past(i_rst_b, 2))
		|-> (br_sync == $past(i_bus_request_n, 2)))
		else $error("request synchroniser depth wrong");

	// -----------------------------------------------------------------
	// Checks on halt, hung grant, wait, bus drivers, chip reset and pin selection
	// -----------------------------------------------------------------
	// Without continue mode the core stops in the very cycle the bus goes
	plain_mode_halts_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state_q == EBRG_OWN && req && !i_acc_busy && !i_go_mode) |=> o_core_halt)
		else $error("core not halted on grant");
	// The wait ends exactly one cycle after the access completes
	wait_then_grant_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state_q == EBRG_WAIT && req && !i_acc_busy) |=> (state_q == EBRG_GRANT))
		else $error("grant late after access");
	// A core that needs the bus while it is away must stop and say so
	need_stops_core_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state_q == EBRG_GRANT && req && i_acc_need) |=> (o_core_halt && !o_grant_hung_n))
		else $error("core needs bus but runs on");
	// Once stopped, the core stays stopped until the master lets go
	halt_sticks_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && state_q == EBRG_GRANT && req && o_core_halt) |=> o_core_halt)
		else $error("core resumed while granted");
	// Hung grant from a running core would mislead the outside master
	hung_means_halt_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		!o_grant_hung_n |-> o_core_halt)
		else $error("hung grant while core runs");
	// Bus drivers are back whenever the bus is not handed out
	drive_when_owned_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(state_q != EBRG_GRANT) |-> o_bus_drive_en)
		else $error("bus floated while owned");
	// Chip reset held low must not hold off a grant
	reset_no_block_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(i_ce && !o_core_reset_n && state_q == EBRG_OWN && req && !i_acc_busy)
		|=> (state_q == EBRG_GRANT))
		else $error("grant blocked by chip reset");
	// Only one grant pin may show a grant at a time
	one_grant_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		o_bus_grant_n || o_emulator_bus_grant_n)
		else $error("both grant pins active");
	// In emulation the grant shows on the emulator pin
	emu_grant_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
		(state_q == EBRG_GRANT && !csel_q) |-> !o_emulator_bus_grant_n)
		else $error("emulator grant missing");
endmodule
`default_nettype wire

// ==== bench/ebrg_master_model.sv ====
// Purpose: Outside bus master model
// Assumes: Grant is active low
// Notes: Drives the bus only while granted
`timescale 1ns/10ps
`default_nettype none
module ebrg_master_model (
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	input wire logic i_want,
	input wire logic i_bus_grant_n,
	output logic o_bus_request_n,
	output logic o_bus_use
);
	// ------------
	// Request pin
	// ------------
	// Changes just after a falling edge, never near the sampling edge
	always_ff @(negedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_bus_request_n <= 1'b1;
		end else begin
			o_bus_request_n <= ~i_want;
		end
	end
	// Uses the bus only under grant, since request may be ignored
	assign o_bus_use = ~o_bus_request_n & ~i_bus_grant_n;
endmodule
`default_nettype wire

// ==== bench/test_external_bus_request_grant.sv ====
// Purpose: Self-checking bench for the bus request/grant arbiter
// Assumes: Pin to grant takes three rising edges
// Notes: Inputs change on falling edges
`timescale 1ns/10ps
`default_nettype none
module test_external_bus_request_grant;
	// ---------------
	// Signals, tasks
	// ---------------
	logic clk, rst_b, want, br_n, use_b, ebr_n, crst_n, erst_n, ee, go, busy, need;
	logic bg_n, oe, ebg_n, hung_n, drv, halt, core_rst_n;
	logic ce;
	int bad_count = 0;
	int n_tests = 0;
	int cyc_n = 0;
	ebrg_master_model mst (.i_clk_sys(clk), .i_rst_b(rst_b), .i_want(want),
		.i_bus_grant_n(bg_n), .o_bus_request_n(br_n), .o_bus_use(use_b));
	ebrg_arbiter uut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce),
		.i_bus_request_n(br_n), .i_emulator_bus_request_n(ebr_n),
		.i_chip_reset_n(crst_n), .i_emulator_reset_n(erst_n), .i_emulator_enable(ee),
		.i_go_mode(go), .i_acc_busy(busy), .i_acc_need(need), .o_bus_grant_n(bg_n),
		.o_bus_grant_n_oe(oe), .o_emulator_bus_grant_n(ebg_n), .o_grant_hung_n(hung_n),
		.o_bus_drive_en(drv), .o_core_halt(halt), .o_core_reset_n(core_rst_n));
	task automatic chk(input string nm, input logic e, input logic g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------
	// Scenarios
	// ----------
	// Plain grant, hung grant, release; model pin lags one falling edge
	task automatic t_plain;
		want <= 1'b1;
		wt(3);
		chk("grant early", 1'b1, bg_n);
		wt(1);
		chk("grant", 1'b0, bg_n);
		chk("drive", 1'b0, drv);
		chk("halt", 1'b1, halt);
		chk("use", 1'b1, use_b);
		need <= 1'b1;
		wt(2);
		chk("hung", 1'b0, hung_n);
		want <= 1'b0;
		wt(3);
		chk("grant held", 1'b0, bg_n);
		wt(1);
		chk("grant off", 1'b1, bg_n);
		chk("hung off", 1'b1, hung_n);
		chk("drive on", 1'b1, drv);
		chk("halt off", 1'b0, halt);
		need <= 1'b0;
		$display("test plain done");
	endtask
	task automatic t_busy;
		busy <= 1'b1;
		want <= 1'b1;
		wt(8);
		chk("busy grant", 1'b1, bg_n);
		chk("busy drive", 1'b1, drv);
		busy <= 1'b0;
		wt(2);
		chk("gap grant", 1'b0, bg_n);
		want <= 1'b0;
		wt(5);
		$display("test busy done");
	endtask
	task automatic t_go;
		go <= 1'b1;
		want <= 1'b1;
		wt(4);
		chk("go grant", 1'b0, bg_n);
		chk("go runs", 1'b0, halt);
		need <= 1'b1;
		wt(1);
		chk("go halt", 1'b1, halt);
		chk("go hung", 1'b0, hung_n);
		want <= 1'b0;
		wt(4);
		chk("go resume", 1'b0, halt);
		need <= 1'b0;
		go <= 1'b0;
		$display("test go done");
	endtask
	// Chip reset held while a request comes in
	task automatic t_rst;
		crst_n <= 1'b0;
		want <= 1'b1;
		wt(4);
		chk("core reset", 1'b0, core_rst_n);
		chk("reset grant", 1'b0, bg_n);
		want <= 1'b0;
		crst_n <= 1'b1;
		wt(4);
		$display("test reset done");
	endtask
	task automatic t_emu;
		ee <= 1'b1;
		want <= 1'b1;
		wt(5);
		chk("grant oe", 1'b0, oe);
		chk("emu grant", 1'b1, ebg_n);
		chk("use", 1'b0, use_b);
		ebr_n <= 1'b0;
		erst_n <= 1'b0;
		wt(4);
		chk("emu grant", 1'b0, ebg_n);
		chk("emu normal grant", 1'b1, bg_n);
		chk("emu reset", 1'b0, core_rst_n);
		ebr_n <= 1'b1;
		erst_n <= 1'b1;
		want <= 1'b0;
		ee <= 1'b0;
		wt(5);
		chk("oe back", 1'b1, oe);
		$display("test emulator done");
	endtask
	// Clock enable low freezes a grant even after the request drops
	task automatic t_ce;
		want <= 1'b1;
		wt(4);
		chk("ce grant", 1'b0, bg_n);
		ce <= 1'b0;
		want <= 1'b0;
		wt(6);
		chk("ce frozen", 1'b0, bg_n);
		ce <= 1'b1;
		wt(3);
		chk("ce release", 1'b1, bg_n);
		chk("ce drive", 1'b1, drv);
		$display("test clock enable done");
	endtask
	// Logic reset in mid grant, then a fresh grant through idle synchronisers
	task automatic t_lrst;
		want <= 1'b1;
		wt(4);
		chk("pre reset grant", 1'b0, bg_n);
		rst_b <= 1'b0;
		wt(1);
		chk("reset grant off", 1'b1, bg_n);
		chk("reset drive", 1'b1, drv);
		chk("reset halt", 1'b0, halt);
		chk("reset hung", 1'b1, hung_n);
		rst_b <= 1'b1;
		wt(3);
		chk("regrant early", 1'b1, bg_n);
		wt(1);
		chk("regrant", 1'b0, bg_n);
		want <= 1'b0;
		wt(6);
		$display("test logic reset done");
	endtask
	// ----------------
	// Clock and flow
	// ----------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Ceiling far above the roughly 100 cycles the tests need
	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 500) begin
			bad_count++;
			report_and_stop;
		end
	end
	initial begin
		{want, ee, go, busy, need, rst_b} = 6'h00;
		{ebr_n, crst_n, erst_n} = 3'h7;
		ce = 1'b1;
		wt(6);
		rst_b <= 1'b1;
		wt(2);
		chk("idle drive", 1'b1, drv);
		t_plain;
		t_busy;
		t_go;
		t_rst;
		t_emu;
		t_ce;
		t_lrst;
		report_and_stop;
	end
endmodule
`default_nettype wire
